// ==== rtl/sfts_params.svh ====
// sizes, field positions and reset values of the flow-through sram port
`ifndef SFTS_PARAMS_SVH
`define SFTS_PARAMS_SVH

`define SFTS_ADDR_W      17
`define SFTS_DEPTH       131072
`define SFTS_LANES       4
`define SFTS_LANE_DQ_W   8
`define SFTS_LANE_W      9
`define SFTS_WORD_W      36
`define SFTS_DQ_W        32
`define SFTS_CNT_W       2
`define SFTS_ADDR_RST    17'h00000
`define SFTS_WORD_RST    36'h000000000
`define SFTS_CNT_RST     2'h0
`define SFTS_LANES_RST   4'hF

`endif

// ==== rtl/sfts_pkg.sv ====
// types and shared functions of the flow-through sram port
`include "sfts_params.svh"

package sfts_pkg;

  typedef logic [`SFTS_ADDR_W-1:0] sfts_addr_t;
  typedef logic [`SFTS_WORD_W-1:0] sfts_word_t;
  typedef logic [`SFTS_LANES-1:0]  sfts_lanes_t;
  typedef logic [`SFTS_CNT_W-1:0]  sfts_cnt_t;

  typedef enum logic [1:0] {
    SFTS_IDLE,
    SFTS_READ,
    SFTS_WRITE
  } sfts_op_t;

  typedef struct packed {
    sfts_op_t    op;
    sfts_addr_t  base;
    sfts_cnt_t   cnt;
    logic        wr_pend;
    sfts_addr_t  wr_addr;
    sfts_lanes_t wr_lanes_n;
    sfts_word_t  rd_word;
    logic        drive;
  } sfts_state_t;

  // burst address: low bits stepped in linear or interleaved order
  function automatic sfts_addr_t sfts_burst_addr(
    input sfts_addr_t base,
    input sfts_cnt_t  cnt,
    input logic       interleave
  );
    sfts_cnt_t low;
    low = interleave ? (base[`SFTS_CNT_W-1:0] ^ cnt)
                     : sfts_cnt_t'(base[`SFTS_CNT_W-1:0] + cnt);
    return {base[`SFTS_ADDR_W-1:`SFTS_CNT_W], low};
  endfunction : sfts_burst_addr

  // lane merge: lanes whose active-low select is low take new data
  function automatic sfts_word_t sfts_merge(
    input sfts_word_t  old_word,
    input sfts_word_t  new_word,
    input sfts_lanes_t lanes_n
  );
    sfts_word_t res;
    res = old_word;
    for (int k = 0; k < `SFTS_LANES; k++) begin
      if (!lanes_n[k]) begin
        res[k*`SFTS_LANE_W +: `SFTS_LANE_W] =
          new_word[k*`SFTS_LANE_W +: `SFTS_LANE_W];
      end
    end
    return res;
  endfunction : sfts_merge

endpackage : sfts_pkg

// ==== rtl/sfts_mem_if.sv ====
// interface between the port control and the storage array
`timescale 1ns/1ps

interface sfts_mem_if;
  logic                 we;
  sfts_pkg::sfts_addr_t waddr;
  sfts_pkg::sfts_word_t wdata;
  sfts_pkg::sfts_lanes_t lanes_n;
  sfts_pkg::sfts_addr_t raddr;
  sfts_pkg::sfts_word_t rdata;

  modport ctrl  (output we, waddr, wdata, lanes_n, raddr, input rdata);
  modport store (input we, waddr, wdata, lanes_n, raddr, output rdata);
endinterface : sfts_mem_if

// ==== rtl/sfts_store.sv ====
// storage array of 128k words by 36 bits with per-lane writes
`timescale 1ns/1ps
`include "sfts_params.svh"

module sfts_store (
  input  wire logic clock_i,
  sfts_mem_if.store m
);

  sfts_pkg::sfts_word_t mem [`SFTS_DEPTH];

  // ************************************************************
  // self-timed write and flow-through read
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (m.we) begin
      mem[m.waddr] <= sfts_pkg::sfts_merge(mem[m.waddr], m.wdata,
                                           m.lanes_n);
    end
  end

  assign m.rdata = mem[m.raddr];

endmodule : sfts_store

// ==== rtl/sfts_port.sv ====
// pin-level control of the synchronous flow-through burst sram port
// Operation
// - every synchronous input is taken in on the rising clock edge.
// - with the clock gate high the edge is ignored and all state holds.
// - reads and writes follow each other in any order with no wait state.
// - writes use the write strobe and four lane selects, self-timed inside.
// - data drivers are off during the data cycle of every write.
// - the port is selected only with select a low, b high and c low.
// - the asynchronous output enable gates the data drivers at any time.
// - a 17-bit address picks one of the 128k words.
// - only lanes with a low lane select are written, parity bit included.
// - bursts step their address in linear or interleaved order.
// - driver turnaround is sequenced inside even with output enable held.
// - a low write strobe on a taken load edge with the port selected starts a write, else a read.
// - step-or-load high advances the burst counter except when idle, low loads an address.
// - read data of the previous edge's address shows; deselect on a load edge turns off.
`timescale 1ns/1ps
`include "sfts_params.svh"

module sfts_port (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        clock_gate_n_i,
  input  wire logic [16:0] addr_i,
  input  wire logic        chip_select_a_n_i,
  input  wire logic        chip_select_b_i,
  input  wire logic        chip_select_c_n_i,
  input  wire logic        write_n_i,
  input  wire logic [3:0]  byte_lane_write_n_i,
  input  wire logic        burst_step_or_load_i,
  input  wire logic        burst_interleave_i,
  input  wire logic        out_enable_n_i,
  input  wire logic [31:0] dq_i,
  input  wire logic [3:0]  parity_lines_i,
  output logic      [31:0] dq_o,
  output logic      [3:0]  parity_lines_o,
  output logic             dq_oe_o,
  output logic             parity_lines_oe_o
);

  sfts_pkg::sfts_state_t s;
  sfts_pkg::sfts_state_t next_s;
  sfts_pkg::sfts_addr_t  acc_addr;
  sfts_pkg::sfts_cnt_t   step_cnt;
  sfts_pkg::sfts_word_t  in_word;
  logic                  selected;

  sfts_mem_if mem_if ();

  sfts_store u_store (
    .clock_i (clock_i),
    .m       (mem_if.store)
  );

  // ************************************************************
  // pin word packing
  // ************************************************************
  always_comb begin
    for (int k = 0; k < `SFTS_LANES; k++) begin
      in_word[k*`SFTS_LANE_W +: `SFTS_LANE_W] =
        {parity_lines_i[k], dq_i[k*`SFTS_LANE_DQ_W +: `SFTS_LANE_DQ_W]};
    end
  end

  assign selected = !chip_select_a_n_i && chip_select_b_i &&
                    !chip_select_c_n_i;

  // ************************************************************
  // access address of this edge
  // ************************************************************
  always_comb begin
    step_cnt = s.cnt;
    acc_addr = s.base;
    if (burst_step_or_load_i) begin
      if (s.op != sfts_pkg::SFTS_IDLE) begin
        step_cnt = sfts_pkg::sfts_cnt_t'(s.cnt + 2'h1);
      end
      acc_addr = sfts_pkg::sfts_burst_addr(s.base, step_cnt,
                                           burst_interleave_i);
    end else if (selected) begin
      acc_addr = addr_i;
    end
  end

  // read address leaves this block alone, so no loop through the array
  assign mem_if.raddr = acc_addr;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s         = s;
    mem_if.we      = 1'b0;
    mem_if.waddr   = s.wr_addr;
    mem_if.wdata   = in_word;
    mem_if.lanes_n = s.wr_lanes_n;
    if (!clock_gate_n_i) begin
      // data cycle of the pending write completes on this edge
      mem_if.we = s.wr_pend;
      if (burst_step_or_load_i) begin
        next_s.cnt = step_cnt;
      end else if (selected) begin
        next_s.op   = write_n_i ? sfts_pkg::SFTS_READ
                                : sfts_pkg::SFTS_WRITE;
        next_s.base = addr_i;
        next_s.cnt  = `SFTS_CNT_RST;
      end else begin
        next_s.op = sfts_pkg::SFTS_IDLE;
      end
      next_s.wr_pend    = (next_s.op == sfts_pkg::SFTS_WRITE);
      next_s.wr_addr    = acc_addr;
      next_s.wr_lanes_n = byte_lane_write_n_i;
      // drivers on only for the data cycle of a read
      next_s.drive      = (next_s.op == sfts_pkg::SFTS_READ);
      if (mem_if.we && (mem_if.waddr == acc_addr)) begin
        next_s.rd_word = sfts_pkg::sfts_merge(mem_if.rdata, in_word,
                                              s.wr_lanes_n);
      end else begin
        next_s.rd_word = mem_if.rdata;
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s.op         <= sfts_pkg::SFTS_IDLE;
      s.base       <= `SFTS_ADDR_RST;
      s.cnt        <= `SFTS_CNT_RST;
      s.wr_pend    <= 1'b0;
      s.wr_addr    <= `SFTS_ADDR_RST;
      s.wr_lanes_n <= `SFTS_LANES_RST;
      s.rd_word    <= `SFTS_WORD_RST;
      s.drive      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // pin outputs
  // ************************************************************
  always_comb begin
    for (int k = 0; k < `SFTS_LANES; k++) begin
      dq_o[k*`SFTS_LANE_DQ_W +: `SFTS_LANE_DQ_W] =
        s.rd_word[k*`SFTS_LANE_W +: `SFTS_LANE_DQ_W];
      parity_lines_o[k] =
        s.rd_word[k*`SFTS_LANE_W + `SFTS_LANE_DQ_W];
    end
  end

  // asynchronous output enable gates the registered drive
  assign dq_oe_o           = s.drive && !out_enable_n_i;
  assign parity_lines_oe_o = s.drive && !out_enable_n_i;

endmodule : sfts_port

// ==== testbench/sfts_port_sva.sv ====
// assertions on the pins of the flow-through sram port
`timescale 1ns/1ps
module sfts_port_sva (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        clock_gate_n_i,
  input wire logic        chip_select_a_n_i,
  input wire logic        chip_select_b_i,
  input wire logic        chip_select_c_n_i,
  input wire logic        write_n_i,
  input wire logic        burst_step_or_load_i,
  input wire logic        out_enable_n_i,
  input wire logic [31:0] dq_o,
  input wire logic [3:0]  parity_lines_o,
  input wire logic        dq_oe_o,
  input wire logic        parity_lines_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic ld;
  logic sel;
  assign ld  = !clock_gate_n_i && !burst_step_or_load_i;
  assign sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
  a_oe_gate: assert property (
    out_enable_n_i |-> !dq_oe_o) else $error("drive with oe high");
  a_lane_pair: assert property (
    dq_oe_o == parity_lines_oe_o) else $error("oe pair differs");
  a_write_off: assert property (
    ld && sel && !write_n_i |=> !dq_oe_o) else $error("write drives");
  a_desel_off: assert property (
    ld && !sel |=> !dq_oe_o) else $error("deselect drives");
  a_read_on: assert property (
    ld && sel && write_n_i ##1 !out_enable_n_i |-> dq_oe_o)
    else $error("read not driven");
  a_stall_data: assert property (
    clock_gate_n_i |=> $stable({parity_lines_o, dq_o}))
    else $error("data moved in stall");
  a_stall_drive: assert property (
    clock_gate_n_i ##1 $stable(out_enable_n_i) |-> $stable(dq_oe_o))
    else $error("drive moved in stall");
  a_reset_off: assert property (
    $rose(rst_b_i) |-> !dq_oe_o) else $error("drive after reset");
endmodule : sfts_port_sva

bind sfts_port sfts_port_sva u_sva (.*);

// ==== testbench/sfts_ctrl_model.sv ====
// controller side of the shared data wires
`timescale 1ns/1ps
module sfts_ctrl_model (
  input  wire logic        clock_i,
  input  wire logic        drive_i,
  input  wire logic [35:0] wdata_i,
  input  wire logic        dut_oe_i,
  input  wire logic [35:0] dut_data_i,
  output logic      [35:0] wire_o
);
  logic [35:0] last;
  always_ff @(posedge clock_i) last <= wire_o;
  always_comb begin
    if (dut_oe_i) wire_o = dut_data_i;
    else if (drive_i) wire_o = wdata_i;
    else wire_o = ~last;
  end
endmodule : sfts_ctrl_model

// ==== testbench/sync_flow_through_sram_port_tb.sv ====
// self-checking bench of the flow-through sram port
`timescale 1ns/1ps
module sync_flow_through_sram_port_tb;
  logic        clock_i, rst_b_i, clock_gate_n_i, write_n_i, drv, pend;
  logic        chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i;
  logic        burst_step_or_load_i, burst_interleave_i, out_enable_n_i;
  logic        dq_oe_o, parity_lines_oe_o;
  logic [3:0]  byte_lane_write_n_i, parity_lines_i, parity_lines_o, pl;
  logic [16:0] addr_i, ba, pa, ea;
  logic [31:0] dq_i, dq_o;
  logic [35:0] wire_v, wdat, o, mem [int];
  logic [14:0] g;
  logic [2:0]  cs;
  logic [1:0]  cnt;
  int          op, mismatches, tests_run, cycles;
  assign {parity_lines_i, dq_i} = wire_v;
  sfts_port u_dut (.clock_i, .rst_b_i, .clock_gate_n_i, .addr_i,
    .chip_select_a_n_i, .chip_select_b_i, .chip_select_c_n_i, .write_n_i,
    .byte_lane_write_n_i, .burst_step_or_load_i, .burst_interleave_i,
    .out_enable_n_i, .dq_i, .parity_lines_i, .dq_o, .parity_lines_o,
    .dq_oe_o, .parity_lines_oe_o);
  sfts_ctrl_model u_ctrl (.clock_i, .drive_i(drv), .wdata_i(wdat),
    .dut_oe_i(dq_oe_o), .dut_data_i({parity_lines_o, dq_o}),
    .wire_o(wire_v));
  task automatic check(input string n, input logic [35:0] s, e);
    tests_run++;
    if (s !== e || $isunknown(s)) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic cyc(input bit st, sel, stl, rnd);
    @(negedge clock_i);
    do cs = 3'($urandom); while (!sel && cs == 3'h2);
    {chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i} = sel ? 3'h2 : cs;
    burst_step_or_load_i = st;
    write_n_i = rnd ? 1'($urandom) : 1'b0;
    byte_lane_write_n_i = rnd ? 4'($urandom) : 4'h0;
    addr_i = {g, 2'($urandom)};
    out_enable_n_i = ($urandom % 4) == 0;
    wdat = {4'($urandom), 32'($urandom)};
    drv = pend;
    if (stl) begin
      clock_gate_n_i = 1'b1;
      o = {parity_lines_o, dq_o};
      @(negedge clock_i);
      check("stall", {parity_lines_o, dq_o}, o);
      clock_gate_n_i = 1'b0;
    end
    @(posedge clock_i);
    #1;
    for (int k = 0; k < 4; k++) begin
      if (pend && !pl[k]) begin
        mem[pa][8*k+:8] = wdat[8*k+:8];
        mem[pa][32+k] = wdat[32+k];
      end
    end
    if (!st) begin
      op = !sel ? 0 : write_n_i ? 1 : 2;
      ba = addr_i;
      cnt = 2'h0;
    end else cnt++;
    ea = {ba[16:2], burst_interleave_i ? ba[1:0] ^ cnt : ba[1:0] + cnt};
    pend = op == 2;
    pa = ea;
    pl = byte_lane_write_n_i;
    check("drive", 36'(dq_oe_o), 36'(op == 1 && !out_enable_n_i));
    check("pdrive", 36'(parity_lines_oe_o),
      36'(op == 1 && !out_enable_n_i));
    if (op == 1) check("read", {parity_lines_o, dq_o}, mem[ea]);
  endtask : cyc
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h42BE));
    {rst_b_i, clock_gate_n_i, write_n_i, drv, pend} = 5'h00;
    {chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i} = 3'h5;
    {burst_step_or_load_i, burst_interleave_i, out_enable_n_i} = 3'h0;
    {byte_lane_write_n_i, addr_i, wdat, op} = '0;
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      burst_interleave_i = p[0];
      g = 15'($urandom);
      for (int i = 0; i < 4; i++) cyc(i != 0, 1'b1, 1'b0, 1'b0);
      repeat (150) cyc($urandom % 3 != 0, $urandom % 5 != 0,
        $urandom % 6 == 0, 1'b1);
    end
    summarize();
  end
endmodule : sync_flow_through_sram_port_tb
